// File: verilog/tpr_pkg.sv
// Shared constants and types for the two-port read-register memory block
`default_nettype none

package tpr_pkg;

  // ----------------------------------------------------------------
  // Memory organisation
  // ----------------------------------------------------------------
  localparam int MEM_ADDR_W = 6;                 // 64 words
  localparam int MEM_DATA_W = 12;                // 12 bits each, 768 bits in all
  localparam int APB_DATA_W = 32;
  localparam int APB_ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register offsets on the APB side (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CFG_ADDR = 12'h000;   // Word pointer for controller access
  localparam logic [11:0] OFS_CFG_DATA = 12'h004;   // Memory word at the pointer
  localparam logic [11:0] OFS_STATUS   = 12'h008;   // Lock, refused flag, read address

  // ----------------------------------------------------------------
  // Status field layout
  // ----------------------------------------------------------------
  localparam int ST_LOCK_BIT    = 0;
  localparam int ST_REFUSED_BIT = 2;
  localparam int ST_BLK_BIT     = 7;
  localparam int ST_RADDR_LSB   = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Controller access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    APB_IDLE,
    APB_HOLD,
    APB_DONE
  } tpr_apb_state_type;

endpackage

`default_nettype wire

// File: verilog/tpr_rdreg.sv
// Optional read-path register with enable, synchronous load, async load and bypass
`default_nettype none

module tpr_rdreg #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         edge_hit,
  input  wire logic [W-1:0] d,
  input  wire logic         bypass,
  input  wire logic         en,
  input  wire logic         sl_n,
  input  wire logic [W-1:0] sd,
  input  wire logic         al_n,
  input  wire logic [W-1:0] ad_n,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] val;
  } tpr_rdreg_state_type;

  tpr_rdreg_state_type s_q;
  tpr_rdreg_state_type s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Async load dominates; otherwise only a read-clock rising edge moves it
  always_comb begin
    s_d = s_q;
    if (!al_n) begin
      s_d.val = ~ad_n;                           // see [RULE8]
    end else if (!bypass && edge_hit && en) begin
      s_d.val = sl_n ? d : sd;                   // see [RULE9] see [RULE10]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Output
  // ----------------------------------------------------------------
  // Async load shows at once, without waiting for the sampling clock
  always_comb begin
    if (!al_n) begin
      q = ~ad_n;                                 // see [RULE8]
    end else if (bypass) begin
      q = d;                                     // see [RULE11]
    end else begin
      q = s_q.val;                               // see [RULE10]
    end
  end

endmodule

`default_nettype wire

// File: verilog/tpr_mem.sv
// Storage array: one write port, one fabric read port, one controller read port
`default_nettype none

module tpr_mem #(
  parameter int AW = 6,
  parameter int DW = 12
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data,
  input  wire logic [AW-1:0] cfg_addr,
  output logic      [DW-1:0] cfg_data
);

  localparam int DEPTH = 2 ** AW;

  // Contents are not reset: a real array has no reset either
  logic [DW-1:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // Write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;                 // see [RULE2]
    end
  end

  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  // Read of a word being written this cycle returns the old word,
  // no collision check is made
  assign rd_data  = mem_q[rd_addr];              // see [RULE5] see [RULE16]
  assign cfg_data = mem_q[cfg_addr];

endmodule

`default_nettype wire

// File: verilog/tpr_top.sv
// Two-port 64x12 memory with optional read-address and read-data registers
//
// Overview of operation
// [RULE1] Storage is 64 words of 12 bits, one write port, one read port.
// [RULE2] Write address, data and enable sampled on write clock rise; store if enabled.
// [RULE3] Read address register and read data register each optional: four read modes.
// [RULE4] Write side and read registers act on rising edges of separate clocks.
// [RULE5] Same-word read and write together gives unknown read data; write still lands. The code returns the old word instead.
// [RULE6] Block select high performs the read; low forces read data to zero.
// [RULE7] Unbypassed address register also captures block select with the read address.
// [RULE8] Active-low async load puts complement of its value in at once, overriding all.
// [RULE9] Clock rise with enable and sync load asserted loads sync load value.
// [RULE10] Register holds without enabled rise; enabled rise without sync load takes input.
// [RULE11] Bypassed register passes its input straight through unless async load active.
// [RULE12] Fabric sets read address, select and enables up before read clock rise.
// [RULE13] Fabric ties bypass selects, sync load values, address async value, lock.
// [RULE14] Lock high stops the configuration controller reaching the memory.
// [RULE15] Busy output high while the configuration controller accesses the memory.
// [RULE16] Both registers bypassed: read data follows current address, gated by select.
`default_nettype none

module tpr_top #(
  parameter int ADDR_W = tpr_pkg::MEM_ADDR_W,
  parameter int DATA_W = tpr_pkg::MEM_DATA_W
) (
  input  wire logic                          CLK_SYS,
  input  wire logic                          RESETN,
  // Write port
  input  wire logic                          W_CLK,
  input  wire logic                          W_EN,
  input  wire logic [ADDR_W-1:0]             W_ADDR,
  input  wire logic [DATA_W-1:0]             W_DATA,
  // Read port
  input  wire logic                          R_CLK,
  input  wire logic                          READ_BLOCK_SELECT,
  input  wire logic [ADDR_W-1:0]             R_ADDR,
  input  wire logic                          RADDR_BYPASS,
  input  wire logic                          RADDR_EN,
  input  wire logic                          RADDR_SYNC_LOAD_N,
  input  wire logic [ADDR_W:0]               RADDR_SYNC_LOAD_VALUE,
  input  wire logic                          RADDR_ASYNC_LOAD_N,
  input  wire logic [ADDR_W:0]               RADDR_ASYNC_LOAD_VALUE_N,
  output logic      [DATA_W-1:0]             R_DATA,
  input  wire logic                          RDATA_BYPASS,
  input  wire logic                          RDATA_EN,
  input  wire logic                          RDATA_SYNC_LOAD_N,
  input  wire logic [DATA_W-1:0]             RDATA_SYNC_LOAD_VALUE,
  input  wire logic                          RDATA_ASYNC_LOAD_N,
  input  wire logic [DATA_W-1:0]             RDATA_ASYNC_LOAD_VALUE_N,
  // Configuration controller side
  input  wire logic                          CONFIG_ACCESS_LOCK,
  output logic                               ACCESS_BUSY,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [tpr_pkg::APB_ADDR_W-1:0] PADDR,
  input  wire logic [tpr_pkg::APB_DATA_W-1:0] PWDATA,
  output logic      [tpr_pkg::APB_DATA_W-1:0] PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Words and the status address field must fit one APB data word
  if (DATA_W < 1 || DATA_W > tpr_pkg::APB_DATA_W) begin : g_bad_data_w
    $error("DATA_W must lie between 1 and the APB data width");
  end
  if (ADDR_W < 1 || ADDR_W + tpr_pkg::ST_RADDR_LSB > tpr_pkg::APB_DATA_W) begin : g_bad_addr_w
    $error("ADDR_W does not fit the status register");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                              w_prev;
    logic                              r_prev;
    tpr_pkg::tpr_apb_state_type        state;
    logic [ADDR_W-1:0]                 cfg_addr;
    logic [tpr_pkg::APB_DATA_W-1:0]    prdata;
    logic                              pslverr;
    logic                              refused;
  } tpr_top_state_type;

  tpr_top_state_type s_q;
  tpr_top_state_type s_d;

  // Rising edge of a port clock seen as a sampled level
  function automatic logic tpr_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  logic              wr_edge;
  logic              rd_edge;
  logic              fab_wr;
  logic              cfg_wr;
  logic              mem_wr;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic [ADDR_W:0]   raddr_out;
  logic [DATA_W-1:0] word_rd;
  logic [DATA_W-1:0] word_gated;
  logic [DATA_W-1:0] cfg_word;
  logic              data_sel;

  // ----------------------------------------------------------------
  // Port clock edges
  // ----------------------------------------------------------------
  // Both port clocks are sampled levels, so each port acts only on its own rise
  assign wr_edge = tpr_rise(W_CLK, s_q.w_prev);    // see [RULE4]
  assign rd_edge = tpr_rise(R_CLK, s_q.r_prev);    // see [RULE4] see [RULE12]

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  // Fabric write has priority; a controller write waits for a free cycle
  assign fab_wr    = wr_edge & W_EN;               // see [RULE2]
  assign cfg_wr    = (s_q.state == tpr_pkg::APB_HOLD) & PWRITE & ~fab_wr;
  assign mem_wr    = fab_wr | cfg_wr;
  assign mem_waddr = fab_wr ? W_ADDR : s_q.cfg_addr;
  assign mem_wdata = fab_wr ? W_DATA : PWDATA[DATA_W-1:0];

  tpr_mem #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .clk      (CLK_SYS),
    .wr_en    (mem_wr),
    .wr_addr  (mem_waddr),
    .wr_data  (mem_wdata),
    .rd_addr  (raddr_out[ADDR_W-1:0]),
    .rd_data  (word_rd),
    .cfg_addr (s_q.cfg_addr),
    .cfg_data (cfg_word)
  );                                               // see [RULE1]

  // ----------------------------------------------------------------
  // Read address register, block select rides along as top bit
  // ----------------------------------------------------------------
  tpr_rdreg #(
    .W (ADDR_W + 1)
  ) u_raddr (
    .clk      (CLK_SYS),
    .rst_n    (RESETN),
    .edge_hit (rd_edge),
    .d        ({READ_BLOCK_SELECT, R_ADDR}),       // see [RULE7]
    .bypass   (RADDR_BYPASS),                      // see [RULE3]
    .en       (RADDR_EN),
    .sl_n     (RADDR_SYNC_LOAD_N),
    .sd       (RADDR_SYNC_LOAD_VALUE),
    .al_n     (RADDR_ASYNC_LOAD_N),
    .ad_n     (RADDR_ASYNC_LOAD_VALUE_N),
    .q        (raddr_out)
  );

  // Deselected block reads as zero before the data register
  assign word_gated = raddr_out[ADDR_W] ? word_rd : '0;   // see [RULE6] see [RULE16]

  // ----------------------------------------------------------------
  // Read data pipeline register
  // ----------------------------------------------------------------
  tpr_rdreg #(
    .W (DATA_W)
  ) u_rdata (
    .clk      (CLK_SYS),
    .rst_n    (RESETN),
    .edge_hit (rd_edge),
    .d        (word_gated),
    .bypass   (RDATA_BYPASS),                      // see [RULE3]
    .en       (RDATA_EN),
    .sl_n     (RDATA_SYNC_LOAD_N),
    .sd       (RDATA_SYNC_LOAD_VALUE),
    .al_n     (RDATA_ASYNC_LOAD_N),
    .ad_n     (RDATA_ASYNC_LOAD_VALUE_N),
    .q        (R_DATA)
  );

  // ----------------------------------------------------------------
  // Controller access over APB
  // ----------------------------------------------------------------
  assign data_sel = (PADDR == tpr_pkg::OFS_CFG_DATA);

  // Every access takes one wait state so read data comes from a flop;
  // memory accesses take at least two, and memory writes take more while the fabric writes
  always_comb begin
    s_d        = s_q;
    s_d.w_prev = W_CLK;
    s_d.r_prev = R_CLK;
    case (s_q.state)
      tpr_pkg::APB_IDLE: begin
        if (PSEL && PENABLE) begin
          s_d.prdata  = tpr_pkg::RST_WORD;
          s_d.pslverr = 1'b0;
          if (data_sel && !CONFIG_ACCESS_LOCK) begin
            s_d.state = tpr_pkg::APB_HOLD;         // see [RULE14]
          end else begin
            s_d.state = tpr_pkg::APB_DONE;
            case (PADDR)
              tpr_pkg::OFS_CFG_ADDR: begin
                if (PWRITE) begin
                  s_d.cfg_addr = PWDATA[ADDR_W-1:0];
                end else begin
                  s_d.prdata[ADDR_W-1:0] = s_q.cfg_addr;
                end
              end
              tpr_pkg::OFS_CFG_DATA: begin
                // Locked: refuse, leave the memory untouched
                s_d.pslverr = 1'b1;                // see [RULE14]
                s_d.refused = 1'b1;
              end
              tpr_pkg::OFS_STATUS: begin
                if (PWRITE) begin
                  if (PWDATA[tpr_pkg::ST_REFUSED_BIT]) begin
                    s_d.refused = 1'b0;
                  end
                end else begin
                  s_d.prdata[tpr_pkg::ST_LOCK_BIT]    = CONFIG_ACCESS_LOCK;
                  s_d.prdata[tpr_pkg::ST_REFUSED_BIT] = s_q.refused;
                  s_d.prdata[tpr_pkg::ST_BLK_BIT]     = raddr_out[ADDR_W];
                  s_d.prdata[tpr_pkg::ST_RADDR_LSB +: ADDR_W] = raddr_out[ADDR_W-1:0];
                end
              end
              default: begin
                s_d.pslverr = 1'b1;
              end
            endcase
          end
        end
      end
      tpr_pkg::APB_HOLD: begin
        // A write stalls while the fabric holds the write port
        if (!(PWRITE && fab_wr)) begin
          s_d.state = tpr_pkg::APB_DONE;
          if (!PWRITE) begin
            s_d.prdata[DATA_W-1:0] = cfg_word;
          end
        end
      end
      tpr_pkg::APB_DONE: begin
        s_d.state = tpr_pkg::APB_IDLE;
      end
      default: begin
        s_d.state = tpr_pkg::APB_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ACCESS_BUSY = (s_q.state == tpr_pkg::APB_HOLD);   // see [RULE15]
  assign PREADY      = (s_q.state == tpr_pkg::APB_DONE);
  assign PRDATA      = s_q.prdata;
  assign PSLVERR     = s_q.pslverr & PREADY;

endmodule

`default_nettype wire

// File: bench/tpr_top_asserts.sv
// Port-level property checker for the two-port read-register memory
`default_nettype none

module tpr_top_asserts #(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 12
) (
  input wire logic                            CLK_SYS,
  input wire logic                            RESETN,
  input wire logic                            R_CLK,
  input wire logic                            READ_BLOCK_SELECT,
  input wire logic                            RADDR_BYPASS,
  input wire logic                            RADDR_EN,
  input wire logic                            RADDR_SYNC_LOAD_N,
  input wire logic                            RADDR_ASYNC_LOAD_N,
  input wire logic [ADDR_W:0]                 RADDR_ASYNC_LOAD_VALUE_N,
  input wire logic [DATA_W-1:0]               R_DATA,
  input wire logic                            RDATA_BYPASS,
  input wire logic                            RDATA_EN,
  input wire logic                            RDATA_SYNC_LOAD_N,
  input wire logic [DATA_W-1:0]               RDATA_SYNC_LOAD_VALUE,
  input wire logic                            RDATA_ASYNC_LOAD_N,
  input wire logic [DATA_W-1:0]               RDATA_ASYNC_LOAD_VALUE_N,
  input wire logic                            CONFIG_ACCESS_LOCK,
  input wire logic                            ACCESS_BUSY,
  input wire logic                            PSEL,
  input wire logic                            PENABLE,
  input wire logic [tpr_pkg::APB_ADDR_W-1:0]  PADDR,
  input wire logic                            PREADY,
  input wire logic                            PSLVERR
);
  timeunit 1ns;
  timeprecision 1ns;

  logic r_clk_q;
  logic r_rise;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  // Read clock rise, detector reset low like the block's
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) r_clk_q <= 1'b0;
    else r_clk_q <= R_CLK;
  end
  assign r_rise = R_CLK && !r_clk_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  property p_sel_zero;
    RADDR_BYPASS && RDATA_BYPASS && RADDR_ASYNC_LOAD_N && RDATA_ASYNC_LOAD_N
      && !READ_BLOCK_SELECT |-> R_DATA == '0;
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("data not zero, select low");

  property p_dat_async;
    !RDATA_ASYNC_LOAD_N |-> R_DATA == ~RDATA_ASYNC_LOAD_VALUE_N;
  endproperty
  a_dat_async: assert property (p_dat_async) else $error("data async load lost");

  property p_adr_async;
    !RADDR_ASYNC_LOAD_N && RDATA_BYPASS && RDATA_ASYNC_LOAD_N
      && RADDR_ASYNC_LOAD_VALUE_N[ADDR_W] |-> R_DATA == '0;
  endproperty
  a_adr_async: assert property (p_adr_async) else $error("address async load lost");

  property p_dat_sync;
    !RDATA_BYPASS && r_rise && RDATA_EN && !RDATA_SYNC_LOAD_N && RDATA_ASYNC_LOAD_N
      |=> !RDATA_ASYNC_LOAD_N || RDATA_BYPASS || R_DATA == $past(RDATA_SYNC_LOAD_VALUE);
  endproperty
  a_dat_sync: assert property (p_dat_sync) else $error("sync load value missed");

  // No enabled rise, no change
  property p_dat_hold;
    !RDATA_BYPASS && RDATA_ASYNC_LOAD_N && !(r_rise && RDATA_EN)
      ##1 !RDATA_BYPASS && RDATA_ASYNC_LOAD_N |-> $stable(R_DATA);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("data register moved");

  property p_sel_reg;
    !RADDR_BYPASS && RDATA_BYPASS && r_rise && RADDR_EN && RADDR_SYNC_LOAD_N
      && RADDR_ASYNC_LOAD_N && !READ_BLOCK_SELECT
      |=> !RADDR_ASYNC_LOAD_N || !RDATA_ASYNC_LOAD_N || RADDR_BYPASS || R_DATA == '0;
  endproperty
  a_sel_reg: assert property (p_sel_reg) else $error("registered select ignored");

  // ----------------------------------------------------------------
  // Controller access
  // ----------------------------------------------------------------
  property p_lock_refuse;
    PSEL && PENABLE && PREADY && PADDR == tpr_pkg::OFS_CFG_DATA
      && CONFIG_ACCESS_LOCK && $past(CONFIG_ACCESS_LOCK) |-> PSLVERR;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("locked access taken");

  property p_lock_idle;
    CONFIG_ACCESS_LOCK && $past(CONFIG_ACCESS_LOCK) && !$past(ACCESS_BUSY) |-> !ACCESS_BUSY;
  endproperty
  a_lock_idle: assert property (p_lock_idle) else $error("busy while locked");

  property p_busy_start;
    PSEL && PENABLE && !PREADY && !ACCESS_BUSY && PADDR == tpr_pkg::OFS_CFG_DATA
      && !CONFIG_ACCESS_LOCK |=> ACCESS_BUSY ##[1:16] (PREADY && !ACCESS_BUSY);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not shown");

  c_busy: cover property ($rose(ACCESS_BUSY));
  c_refuse: cover property (PREADY && PSLVERR);
  c_sync: cover property (r_rise && RDATA_EN && !RDATA_SYNC_LOAD_N);
endmodule

bind tpr_top tpr_top_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) tpr_top_asserts_i (.*);

`default_nettype wire

// File: bench/tpr_fabric.sv
// Fabric-side model that strikes the write clock and the read clock
`default_nettype none

module tpr_fabric (
  input  wire logic        clk,
  output logic             w_clk,
  output logic             w_en,
  output logic [5:0]       w_addr,
  output logic [11:0]      w_data,
  output logic             r_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet port clocks until a beat is asked for
  initial begin
    {w_clk, w_en, r_clk} = 3'h0;
    {w_addr, w_data} = 18'h00000;
  end

  // Write beat; afterwards the lines show the inverse so stale values never match
  task automatic wr(input logic [5:0] a, input logic [11:0] d, input logic en);
    @(posedge clk);
    w_clk <= 1'b1;
    w_en <= en;
    w_addr <= a;
    w_data <= d;
    @(posedge clk);
    w_clk <= 1'b0;
    w_en <= 1'b0;
    w_addr <= ~a;
    w_data <= ~d;
  endtask

  // Read clock beat; controls were set up by the caller before this rise
  task automatic rclk();
    @(posedge clk);
    r_clk <= 1'b1;
    @(posedge clk);
    r_clk <= 1'b0;
  endtask
endmodule

`default_nettype wire

// File: bench/two_port_ram_read_regs_bench.sv
// Self-checking bench for the two-port read-register memory
`default_nettype none

module two_port_ram_read_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        CLK_SYS, RESETN, W_CLK, W_EN, R_CLK, READ_BLOCK_SELECT, s;
  logic [5:0]  W_ADDR, R_ADDR, a;
  logic [11:0] W_DATA, R_DATA, RDATA_SYNC_LOAD_VALUE, RDATA_ASYNC_LOAD_VALUE_N, v, prev;
  logic [6:0]  RADDR_SYNC_LOAD_VALUE, RADDR_ASYNC_LOAD_VALUE_N;
  logic        RADDR_BYPASS, RADDR_EN, RADDR_SYNC_LOAD_N, RADDR_ASYNC_LOAD_N;
  logic        RDATA_BYPASS, RDATA_EN, RDATA_SYNC_LOAD_N, RDATA_ASYNC_LOAD_N;
  logic        CONFIG_ACCESS_LOCK, ACCESS_BUSY, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        err, bsy;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [11:0] mem [64];
  int          error_cnt = 0;
  int          num_checks = 0;

  tpr_top tpr_top_i (
    .CLK_SYS, .RESETN, .W_CLK, .W_EN, .W_ADDR, .W_DATA, .R_CLK, .READ_BLOCK_SELECT,
    .R_ADDR, .RADDR_BYPASS, .RADDR_EN, .RADDR_SYNC_LOAD_N, .RADDR_SYNC_LOAD_VALUE,
    .RADDR_ASYNC_LOAD_N, .RADDR_ASYNC_LOAD_VALUE_N, .R_DATA, .RDATA_BYPASS, .RDATA_EN,
    .RDATA_SYNC_LOAD_N, .RDATA_SYNC_LOAD_VALUE, .RDATA_ASYNC_LOAD_N,
    .RDATA_ASYNC_LOAD_VALUE_N, .CONFIG_ACCESS_LOCK, .ACCESS_BUSY, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR
  );

  tpr_fabric tpr_fabric_i (
    .clk(CLK_SYS), .w_clk(W_CLK), .w_en(W_EN), .w_addr(W_ADDR), .w_data(W_DATA), .r_clk(R_CLK)
  );

  // 10 MHz system clock
  initial begin
    CLK_SYS = 1'b0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end

  function automatic logic [11:0] exp_rd(input logic [5:0] ad, input logic sel);
    return sel ? mem[ad] : 12'h000;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read clock beats, then settle
  task automatic rclk(input int n);
    repeat (n) tpr_fabric_i.rclk();
    @(negedge CLK_SYS);
  endtask

  // APB master: holds request until PREADY, notes busy
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge CLK_SYS);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, ad, wd};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    bsy = 1'b0;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      bsy = bsy | ACCESS_BUSY;
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    err = PSLVERR;
    {PSEL, PENABLE} <= 2'b00;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    RESETN = 1'b0;
    {READ_BLOCK_SELECT, R_ADDR} = 7'h40;
    {RADDR_BYPASS, RDATA_BYPASS, RADDR_EN, RDATA_EN} = 4'hF;
    {RADDR_SYNC_LOAD_N, RADDR_ASYNC_LOAD_N, RDATA_SYNC_LOAD_N, RDATA_ASYNC_LOAD_N} = 4'hF;
    {RADDR_SYNC_LOAD_VALUE, RADDR_ASYNC_LOAD_VALUE_N} = 14'h0000;
    {RDATA_SYNC_LOAD_VALUE, RDATA_ASYNC_LOAD_VALUE_N} = 24'h000000;
    {CONFIG_ACCESS_LOCK, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    void'($urandom(63551));
    repeat (16) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    apb(1'b0, tpr_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h0000_0005, 32'h0);
    // Fill memory; a disabled write must not land
    for (int i = 0; i < 64; i++) begin
      v = (i == 0) ? 12'hFFF : 12'($urandom);
      tpr_fabric_i.wr(6'(i), v, 1'b1);
      mem[i] = v;
    end
    tpr_fabric_i.wr(6'h3F, ~mem[63], 1'b0);
    @(posedge CLK_SYS);
    R_ADDR <= 6'h3F;
    @(negedge CLK_SYS);
    chk(R_DATA, mem[63]);
    // Four read modes: latency 0, 1 and 2 read clock rises
    for (int m = 0; m < 4; m++) begin
      @(posedge CLK_SYS);
      {RADDR_BYPASS, RDATA_BYPASS} <= 2'(m);
      rclk(2);
      prev = exp_rd(R_ADDR, READ_BLOCK_SELECT);
      repeat (12) begin
        a = 6'($urandom);
        s = ($urandom % 4) != 0;
        @(posedge CLK_SYS);
        {R_ADDR, READ_BLOCK_SELECT} <= {a, s};
        @(negedge CLK_SYS);
        chk(R_DATA, m == 3 ? exp_rd(a, s) : prev);
        rclk(1);
        chk(R_DATA, m == 0 ? prev : exp_rd(a, s));
        rclk(1);
        chk(R_DATA, exp_rd(a, s));
        prev = exp_rd(a, s);
      end
    end
    // Data register: sync load, hold, async load
    @(posedge CLK_SYS);
    {RADDR_BYPASS, RDATA_BYPASS, READ_BLOCK_SELECT, RDATA_SYNC_LOAD_N} <= 4'b0010;
    RDATA_SYNC_LOAD_VALUE <= 12'($urandom);
    rclk(1);
    chk(R_DATA, RDATA_SYNC_LOAD_VALUE);
    @(posedge CLK_SYS);
    {RDATA_SYNC_LOAD_N, RDATA_EN} <= 2'b10;
    R_ADDR <= ~R_ADDR;
    rclk(2);
    chk(R_DATA, RDATA_SYNC_LOAD_VALUE);
    @(posedge CLK_SYS);
    RDATA_ASYNC_LOAD_VALUE_N <= 12'($urandom);
    RDATA_ASYNC_LOAD_N <= 1'b0;
    @(negedge CLK_SYS);
    chk(R_DATA, RDATA_ASYNC_LOAD_VALUE_N ^ 12'hFFF);
    @(posedge CLK_SYS);
    RDATA_ASYNC_LOAD_N <= 1'b1;
    @(negedge CLK_SYS);
    chk(R_DATA, RDATA_ASYNC_LOAD_VALUE_N ^ 12'hFFF);
    // Address register: sync load, then async load
    @(posedge CLK_SYS);
    {RDATA_EN, RADDR_SYNC_LOAD_N, RADDR_SYNC_LOAD_VALUE} <= {2'b10, 7'h45};
    rclk(2);
    chk(R_DATA, mem[5]);
    @(posedge CLK_SYS);
    {RADDR_SYNC_LOAD_N, RDATA_BYPASS, RADDR_ASYNC_LOAD_N} <= 3'b110;
    RADDR_ASYNC_LOAD_VALUE_N <= 7'h36;
    @(negedge CLK_SYS);
    chk(R_DATA, mem[9]);
    @(posedge CLK_SYS);
    RADDR_ASYNC_LOAD_VALUE_N <= 7'h76;
    @(negedge CLK_SYS);
    chk(R_DATA, 32'h0);
    // Controller path: busy on write, refusal under lock
    @(posedge CLK_SYS);
    {RADDR_ASYNC_LOAD_N, RADDR_BYPASS, READ_BLOCK_SELECT, R_ADDR} <= {3'b111, 6'h11};
    apb(1'b1, tpr_pkg::OFS_CFG_ADDR, 32'h11);
    v = 12'($urandom);
    apb(1'b1, tpr_pkg::OFS_CFG_DATA, {20'h0, v});
    chk({err, bsy}, 32'h1);
    mem[17] = v;
    apb(1'b0, tpr_pkg::OFS_CFG_DATA, 32'h0);
    chk(rd, {20'h0, v});
    chk(R_DATA, mem[17]);
    @(posedge CLK_SYS);
    CONFIG_ACCESS_LOCK <= 1'b1;
    apb(1'b1, tpr_pkg::OFS_CFG_DATA, {20'h0, ~v});
    chk({err, bsy}, 32'h2);
    apb(1'b0, tpr_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h0000_0005, 32'h5);
    chk(R_DATA, mem[17]);
    apb(1'b0, 12'h00C, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    tally_and_finish();
  end

  // Watchdog: the whole run needs several hundred cycles
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    error_cnt++;
    tally_and_finish();
  end
endmodule

`default_nettype wire
